/* polling_cfg.svh */
// Register map, reset values and timing counts of the self polling timer
`ifndef POLLING_CFG_SVH
`define POLLING_CFG_SVH

`define OFS_IRQ_STATUS      8'h04
`define OFS_IRQ_MASK        8'h05
`define OFS_CHANNEL_STATUS  8'h06
`define OFS_POLL_CONTROL    8'h07
`define OFS_REF_TIMER       8'h08
`define OFS_OFF_TIME_LOW    8'h09
`define OFS_OFF_TIME_HIGH   8'h0a
`define OFS_ACTIVE_PERIODS  8'h0b
`define OFS_IDLE_PERIODS    8'h0c
`define OFS_ON_TIME_A_LOW   8'h1f
`define OFS_ON_TIME_A_HIGH  8'h20
`define OFS_ON_TIME_B_LOW   8'h40
`define OFS_ON_TIME_B_HIGH  8'h41

`define RST_IRQ_STATUS      8'h00
`define RST_IRQ_MASK        8'h00
`define RST_CHANNEL_STATUS  2'h0
`define RST_POLL_CONTROL    8'h00
`define RST_REF_TIMER       8'h01
`define RST_OFF_TIME_LOW    8'h01
`define RST_OFF_TIME_HIGH   8'h00
`define RST_ACTIVE_PERIODS  8'h01
`define RST_IDLE_PERIODS    8'h01
`define RST_ON_TIME_LOW     8'h01
`define RST_ON_TIME_HIGH    8'h00

`define CTRL_CONT_SEARCH    3
`define CTRL_ACTIVE_IDLE    2
`define CTRL_SEL_HI         1
`define CTRL_SEL_LO         0
`define IRQ_WAKE_A          0
`define IRQ_WAKE_B          4

`define SEL_CONSTANT        2'h0
`define SEL_FAST_FALL       2'h1
`define SEL_MIXED           2'h2

`define PRESCALE_LAST       6'h3f
`define TIME_ZERO_TICKS     15'h4000
`define PERIOD_ZERO_COUNT   9'h100

`endif

/* polling_pkg.sv */
// Types shared by the self polling timer modules
package polling_pkg;

    typedef enum logic [1:0] {
        ST_OFF,
        ST_ON,
        ST_WAKE
    } poll_state_type;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } reg_req_type;

    typedef struct packed {
        logic       found;
        logic       detect;
        logic [1:0] channel;
    } wake_in_type;

    typedef struct packed {
        logic [5:0] pre;
        logic [7:0] div;
        logic       tick;
    } tick_state_type;

    typedef struct packed {
        poll_state_type st;
        logic           cfg_b;
        logic           active;
        logic           first;
        logic           sig_seen;
        logic [14:0]    ivl_cnt;
        logic [8:0]     per_cnt;
        logic [7:0]     ctrl;
        logic [7:0]     ref_preset;
        logic [7:0]     off_lo;
        logic [7:0]     off_hi;
        logic [7:0]     ap;
        logic [7:0]     ip;
        logic [7:0]     on_a_lo;
        logic [7:0]     on_a_hi;
        logic [7:0]     on_b_lo;
        logic [7:0]     on_b_hi;
        logic [7:0]     irq_status;
        logic [7:0]     irq_mask;
        logic [1:0]     chan;
        logic [7:0]     rdata;
        logic           irq;
        logic           rx_on;
        logic           search;
    } poll_state_struct_type;

endpackage

/* ref_tick_gen.sv */
// Reference tick: fixed divide by 64, then divide by the 8-bit preset
`timescale 1ns/10ps
`include "polling_cfg.svh"
module ref_tick_gen
    import polling_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] preset_i,
    output logic            tick_o
);

    tick_state_type s_r;
    tick_state_type s_nxt;
    logic           pre_wrap;
    logic           div_last;

    // Preset 00h wraps to ff, which yields the 256 divide
    assign pre_wrap = (s_r.pre == `PRESCALE_LAST);                 // R05
    assign div_last = (s_r.div == 8'(preset_i - 8'h01));           // R05

    always_comb begin
        s_nxt      = s_r;
        s_nxt.pre  = 6'(s_r.pre + 6'h01);
        s_nxt.tick = pre_wrap && div_last;                         // R05
        if (pre_wrap) begin
            s_nxt.div = div_last ? 8'h00 : 8'(s_r.div + 8'h01);
        end
        // A shrunk preset must not strand the divider above it
        if (s_r.div > 8'(preset_i - 8'h01)) begin
            s_nxt.div = 8'h00;
        end
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick_o = s_r.tick;

    a_tick_gap: assert property (@(posedge clk_i) disable iff (!resetn_i)
        tick_o |=> !tick_o [*8]) else $error("ref tick too close"); // R05

endmodule

/* self_polling_timer.sv */
// Self polling timer: reference tick, on/off sequencer, registers, interrupt
//
// Overview of operation
// R01 - After a wake-up, load 2-bit channel code; 00 none, 01-11 setting one-three.
// R02 - Continuous search bit set keeps wake-up search on for whole on-time.
// R03 - Control bit 2 enables active/idle alternation during on-time.
// R04 - Selector: 00 constant, 01 fast fall back, 10 mixed A constant B fast.
// R05 - Reference tick every 64 clocks times preset; preset 00h means 256.
// R06 - Off-time lasts off value ticks; 0000h means 16384 ticks.
// R07 - Off value is 14 bits: low register, then high register bits 5:0.
// R08 - Active periods from bits 4:0; 00h means 256 periods.
// R09 - Idle periods 8 bits; 00h means 256 periods.
// R10 - On-time lasts on value ticks, 0000h is 16384; separate A and B.
// R11 - A found wake-up sets the wake flag of its configuration.
// R12 - On and off intervals alternate, each reloaded from registers at start.
// R13 - Configuration registers write-only; channel status read-only, writes ignored.
//
// Decided for this implementation: strobed register access.
`timescale 1ns/10ps
`include "polling_cfg.svh"
module self_polling_timer
    import polling_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       resetn_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic       wake_found_i,
    input  wire logic       signal_detect_i,
    input  wire logic [1:0] wake_channel_i,
    output logic [7:0]      rdata_o,
    output logic            irq_o,
    output logic            rx_on_o,
    output logic            search_o,
    output logic            cfg_b_o
);

    poll_state_struct_type s_r;
    poll_state_struct_type s_nxt;
    reg_req_type           req;
    wake_in_type           wk;
    logic                  tick;
    logic                  cont_en;
    logic                  ai_en;
    logic [1:0]            sel;
    logic                  fast_mode;
    logic                  wake_hit;
    logic                  ivl_end;
    logic                  per_end;
    logic                  fall_back;
    logic [14:0]           off_load;
    logic [14:0]           on_load;
    logic [8:0]            ap_load;
    logic [8:0]            ip_load;
    logic [7:0]            clr_bits;
    logic [7:0]            set_bits;
    logic                  wake_bit_clr;

    // A zero count stands for one more than the 14-bit or 8-bit argument can hold
    function automatic logic [14:0] ticks_of(input logic [13:0] v);
        ticks_of = (v == 14'h0000) ? `TIME_ZERO_TICKS : {1'b0, v};
    endfunction

    function automatic logic [8:0] periods_of(input logic [7:0] v);
        periods_of = (v == 8'h00) ? `PERIOD_ZERO_COUNT : {1'b0, v};
    endfunction

    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};
    assign wk  = '{found: wake_found_i, detect: signal_detect_i,
                   channel: wake_channel_i};

    ref_tick_gen u_tick (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .preset_i (s_r.ref_preset),
        .tick_o   (tick)
    );

    assign cont_en = s_r.ctrl[`CTRL_CONT_SEARCH];
    assign ai_en   = s_r.ctrl[`CTRL_ACTIVE_IDLE];
    assign sel     = s_r.ctrl[`CTRL_SEL_HI:`CTRL_SEL_LO];

    // Reserved selector code 11 behaves as constant cycling
    assign fast_mode = (sel == `SEL_FAST_FALL) ||
                       ((sel == `SEL_MIXED) && s_r.cfg_b);                 // R04

    assign off_load = ticks_of({s_r.off_hi[5:0], s_r.off_lo});         // R06 R07
    assign on_load  = s_r.cfg_b ? ticks_of({s_r.on_a_hi[5:0], s_r.on_a_lo})
                                : ticks_of({s_r.on_b_hi[5:0], s_r.on_b_lo});
    assign ap_load  = periods_of({3'h0, s_r.ap[4:0]});                     // R08
    assign ip_load  = periods_of(s_r.ip);                                  // R09

    assign wake_hit  = (s_r.st == ST_ON) && s_r.search && wk.found;
    assign ivl_end   = tick && (s_r.ivl_cnt == 15'h0001);
    assign per_end   = tick && (s_r.per_cnt == 9'h001);
    // Fast fall back judges the first reference tick of the on-time
    assign fall_back = (s_r.st == ST_ON) && s_r.first && tick &&
                       fast_mode && !s_r.sig_seen && !wk.detect;           // R04

    assign clr_bits = (req.wr && (req.addr == `OFS_IRQ_STATUS))
                      ? req.wdata : 8'h00;
    assign set_bits = {3'h0, wake_hit && s_r.cfg_b, 3'h0,
                       wake_hit && !s_r.cfg_b};                            // R11
    assign wake_bit_clr = s_r.cfg_b ? clr_bits[`IRQ_WAKE_B]
                                    : clr_bits[`IRQ_WAKE_A];

    always_comb begin
        s_nxt = s_r;

        if (req.wr) begin
            unique case (req.addr)
                `OFS_IRQ_MASK:       s_nxt.irq_mask   = req.wdata;
                `OFS_POLL_CONTROL:   s_nxt.ctrl       = req.wdata;
                `OFS_REF_TIMER:      s_nxt.ref_preset = req.wdata;
                `OFS_OFF_TIME_LOW:   s_nxt.off_lo     = req.wdata;
                `OFS_OFF_TIME_HIGH:  s_nxt.off_hi     = req.wdata;
                `OFS_ACTIVE_PERIODS: s_nxt.ap         = req.wdata;
                `OFS_IDLE_PERIODS:   s_nxt.ip         = req.wdata;
                `OFS_ON_TIME_A_LOW:  s_nxt.on_a_lo    = req.wdata;
                `OFS_ON_TIME_A_HIGH: s_nxt.on_a_hi    = req.wdata;
                `OFS_ON_TIME_B_LOW:  s_nxt.on_b_lo    = req.wdata;
                `OFS_ON_TIME_B_HIGH: s_nxt.on_b_hi    = req.wdata;
                default: ;                                                 // R13
            endcase
        end

        // Only status registers answer reads; the rest read as zero
        s_nxt.rdata = 8'h00;
        if (req.rd) begin
            unique case (req.addr)
                `OFS_CHANNEL_STATUS: s_nxt.rdata = {6'h00, s_r.chan};      // R13
                `OFS_IRQ_STATUS:     s_nxt.rdata = s_r.irq_status;
                default:             s_nxt.rdata = 8'h00;
            endcase
        end

        // Set beats a simultaneous write-one clear
        s_nxt.irq_status = (s_r.irq_status & ~clr_bits) | set_bits;        // R11

        unique case (s_r.st)
            ST_OFF: begin
                if (tick) begin
                    s_nxt.ivl_cnt = 15'(s_r.ivl_cnt - 15'h0001);
                end
                if (ivl_end) begin
                    s_nxt.st       = ST_ON;                                // R12
                    s_nxt.cfg_b    = !s_r.cfg_b;
                    s_nxt.ivl_cnt  = on_load;                              // R10
                    s_nxt.active   = 1'b1;
                    s_nxt.per_cnt  = ap_load;                              // R08
                    s_nxt.first    = 1'b1;
                    s_nxt.sig_seen = 1'b0;
                end
            end
            ST_ON: begin
                if (wk.detect) begin
                    s_nxt.sig_seen = 1'b1;
                end
                if (tick) begin
                    s_nxt.first   = 1'b0;
                    s_nxt.ivl_cnt = 15'(s_r.ivl_cnt - 15'h0001);
                    s_nxt.per_cnt = (s_r.per_cnt != 9'h000)
                                    ? 9'(s_r.per_cnt - 9'h001) : 9'h000;
                end
                if (per_end) begin
                    if (s_r.active && ai_en) begin
                        s_nxt.active  = 1'b0;                              // R03
                        s_nxt.per_cnt = ip_load;                           // R09
                    end else if (!s_r.active && ai_en) begin
                        s_nxt.active  = 1'b1;                              // R03
                        s_nxt.per_cnt = ap_load;                           // R08
                    end else begin
                        s_nxt.active  = 1'b0;
                    end
                end
                if (wake_hit) begin
                    s_nxt.st   = ST_WAKE;
                    s_nxt.chan = wk.channel;                               // R01
                end else if (ivl_end || fall_back) begin
                    s_nxt.st      = ST_OFF;                                // R12
                    s_nxt.ivl_cnt = off_load;                              // R06
                    s_nxt.active  = 1'b0;
                end
            end
            ST_WAKE: begin
                // Receiver stays up until software acknowledges the wake-up
                if (wake_bit_clr) begin
                    s_nxt.st      = ST_OFF;
                    s_nxt.ivl_cnt = off_load;                              // R12
                end
            end
        endcase

        s_nxt.irq    = |(s_nxt.irq_status & ~s_nxt.irq_mask);
        s_nxt.rx_on  = (s_nxt.st == ST_WAKE) ||
                       ((s_nxt.st == ST_ON) &&
                        (s_nxt.active || !s_nxt.ctrl[`CTRL_ACTIVE_IDLE])); // R03
        s_nxt.search = (s_nxt.st == ST_ON) &&
                       (s_nxt.ctrl[`CTRL_CONT_SEARCH] || s_nxt.active);    // R02
    end

    always_ff @(posedge clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            s_r            <= '0;
            s_r.st         <= ST_OFF;
            s_r.ivl_cnt    <= 15'h0001;
            s_r.ctrl       <= `RST_POLL_CONTROL;
            s_r.ref_preset <= `RST_REF_TIMER;
            s_r.off_lo     <= `RST_OFF_TIME_LOW;
            s_r.off_hi     <= `RST_OFF_TIME_HIGH;
            s_r.ap         <= `RST_ACTIVE_PERIODS;
            s_r.ip         <= `RST_IDLE_PERIODS;
            s_r.on_a_lo    <= `RST_ON_TIME_LOW;
            s_r.on_a_hi    <= `RST_ON_TIME_HIGH;
            s_r.on_b_lo    <= `RST_ON_TIME_LOW;
            s_r.on_b_hi    <= `RST_ON_TIME_HIGH;
            s_r.irq_status <= `RST_IRQ_STATUS;
            s_r.irq_mask   <= `RST_IRQ_MASK;
            s_r.chan       <= `RST_CHANNEL_STATUS;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign rdata_o  = s_r.rdata;
    assign irq_o    = s_r.irq;
    assign rx_on_o  = s_r.rx_on;
    assign search_o = s_r.search;
    assign cfg_b_o  = s_r.cfg_b;

    a_chan_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wake_hit |=> (s_r.chan == $past(wk.channel)) && (s_r.st == ST_WAKE))
        else $error("channel code not loaded on wake-up"); // R01

    a_chan_ro: assert property (@(posedge clk_i) disable iff (!resetn_i)
        !$stable(s_r.chan) |-> $past(wake_hit))
        else $error("channel code changed without wake-up"); // R13

    a_search_cont: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && cont_en) |-> search_o)
        else $error("search dropped during continuous on-time"); // R02

    a_idle_rx_off: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && ai_en && !s_r.active) |-> !rx_on_o)
        else $error("receiver on during idle period"); // R03

    a_fast_fall: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (fall_back && !wake_hit) |=>
            (s_r.st == ST_OFF) && (s_r.ivl_cnt == $past(off_load)))
        else $error("fast fall back missed"); // R04

    a_const_stay: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && !fast_mode && !ivl_end && !wake_hit) |=>
            s_r.st == ST_ON)
        else $error("constant mode left on-time early"); // R04

    a_on_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_OFF && ivl_end) |=>
            (s_r.st == ST_ON) && (s_r.ivl_cnt == $past(on_load)) &&
            (s_r.cfg_b != $past(s_r.cfg_b)))
        else $error("on-time not reloaded"); // R10

    a_off_reload: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && ivl_end && !wake_hit) |=>
            (s_r.st == ST_OFF) && (s_r.ivl_cnt == $past(off_load)))
        else $error("off-time not reloaded"); // R06

    a_active_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && per_end && ai_en && !s_r.active &&
         !ivl_end && !fall_back && !wake_hit) |=>
            s_r.active && (s_r.per_cnt == $past(ap_load)))
        else $error("active periods not loaded"); // R08

    a_idle_load: assert property (@(posedge clk_i) disable iff (!resetn_i)
        (s_r.st == ST_ON && per_end && ai_en && s_r.active &&
         !ivl_end && !fall_back && !wake_hit) |=>
            !s_r.active && (s_r.per_cnt == $past(ip_load)))
        else $error("idle periods not loaded"); // R09

    a_wake_flag: assert property (@(posedge clk_i) disable iff (!resetn_i)
        wake_hit |=> s_r.irq_status[$past(s_r.cfg_b) ? `IRQ_WAKE_B
                                                     : `IRQ_WAKE_A]
        ##1 irq_o || s_r.irq_mask != 8'h00)
        else $error("wake flag not set"); // R11

endmodule

/* tb_self_polling_timer.sv */
// Self-checking testbench for the self polling timer
`timescale 1ns/10ps
`include "polling_cfg.svh"
module tb_self_polling_timer
    import polling_pkg::*;
;
    logic        clk_i;
    logic        resetn_i;
    reg_req_type req;
    wake_in_type wk;
    logic [7:0]  rdata_o;
    logic        irq_o;
    logic        rx_on_o;
    logic        search_o;
    logic        cfg_b_o;
    logic [7:0]  exp_q[$];
    logic        rd_d = 1'b0;
    int          n_errors = 0;
    int          n_tests = 0;
    int          seed = 32'h8e1d;
    int          n;
    int          m;
    int          b;
    logic [7:0]  st;
    logic [7:0]  pre[5];
    logic [7:0]  lo[5];
    logic [7:0]  hi[5];

    self_polling_timer u_self_polling_timer (
        .clk_i           (clk_i),
        .resetn_i        (resetn_i),
        .addr_i          (req.addr),
        .wdata_i         (req.wdata),
        .wr_i            (req.wr),
        .rd_i            (req.rd),
        .wake_found_i    (wk.found),
        .signal_detect_i (wk.detect),
        .wake_channel_i  (wk.channel),
        .rdata_o         (rdata_o),
        .irq_o           (irq_o),
        .rx_on_o         (rx_on_o),
        .search_o        (search_o),
        .cfg_b_o         (cfg_b_o)
    );

    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_sim();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk_data(logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected data at %0t: %h vs %h", $time, g, e);
        end
    endtask

    task automatic chk_flag(logic e, logic g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected flag at %0t: %h vs %h", $time, g, e);
        end
    endtask

    task automatic chk_span(int e, int g);
        n_tests++;
        if (g !== e) begin
            n_errors++;
            $display("unexpected span at %0t: %h vs %h", $time, g, e);
        end
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk_i) begin
        if (rd_d === 1'b1 && exp_q.size() > 0) begin
            chk_data(exp_q.pop_front(), rdata_o);
        end
        rd_d <= req.rd;
    end

    task automatic bus(logic w, logic [7:0] a, logic [7:0] d);
        req <= '{addr: a, wdata: d, wr: w, rd: !w};
        @(posedge clk_i);
    endtask

    task automatic idle();
        req <= '{default: '0};
        @(posedge clk_i);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(logic [7:0] a, logic [7:0] e);
        exp_q.push_back(e);
        bus(1'b0, a, 8'h00);
    endtask

    function automatic logic pick(logic s);
        return s ? search_o : rx_on_o;
    endfunction

    // Waits for the level, then counts cycles until it ends
    task automatic span(logic s, logic lvl, output int c);
        int k;
        k = 0;
        c = 0;
        while (pick(s) !== lvl && k < 40000) begin
            @(posedge clk_i);
            k++;
        end
        while (pick(s) === lvl && k < 40000) begin
            @(posedge clk_i);
            k++;
            c++;
        end
    endtask

    // Skips one interval of each level so the counted one starts after any write
    task automatic meas(logic s, logic lvl, output int c);
        span(s, lvl, c);
        span(s, !lvl, c);
        span(s, lvl, c);
    endtask

    task automatic wake(logic [1:0] ch, logic cb);
        int k;
        k = 0;
        while (search_o !== 1'b1 && k < 1000) begin
            @(posedge clk_i);
            k++;
        end
        wk <= '{found: 1'b1, detect: 1'b0, channel: ch};
        @(posedge clk_i);
        wk.found <= 1'b0;
        @(posedge clk_i);
        chk_flag(1'b1, irq_o);
        chk_flag(cb, cfg_b_o);
    endtask

    initial begin
        repeat (90000) @(posedge clk_i);
        n_errors++;
        end_sim();
    end

    initial begin
        resetn_i = 1'b0;
        req = '{default: '0};
        wk = '{default: '0};
        pre = '{8'h01, 8'h01, 8'h01, 8'h03, 8'h00};
        lo = '{8'h01, 8'h02 + 8'({$random(seed)} % 8), 8'h01, 8'h01, 8'h01};
        hi = '{8'h00, 8'h00, 8'hc1, 8'h00, 8'h00};
        repeat (6) @(posedge clk_i);
        resetn_i <= 1'b1;
        @(posedge clk_i);
        chk_flag(1'b0, irq_o);
        rd(`OFS_CHANNEL_STATUS, 8'h00);
        rd(`OFS_IRQ_STATUS, 8'h00);
        for (int a = 7; a <= 12; a++) begin
            rd(8'(a), 8'h00);
        end
        rd(8'h3c, 8'h00);
        idle();
        // First on-time after reset runs configuration B
        for (int i = 0; i < 3; i++) begin
            st = i[0] ? 8'h01 : 8'h10;
            wake(2'(i + 1), !i[0]);
            rd(`OFS_CHANNEL_STATUS, {6'h00, 2'(i + 1)});
            wr(`OFS_CHANNEL_STATUS, 8'($random(seed)));
            rd(`OFS_CHANNEL_STATUS, {6'h00, 2'(i + 1)});
            rd(`OFS_IRQ_STATUS, st);
            wr(`OFS_IRQ_MASK, st);
            idle();
            idle();
            chk_flag(1'b0, irq_o);
            wr(`OFS_IRQ_MASK, 8'h00);
            idle();
            idle();
            chk_flag(1'b1, irq_o);
            wr(`OFS_IRQ_STATUS, st);
            rd(`OFS_IRQ_STATUS, 8'h00);
            idle();
            idle();
            chk_flag(1'b0, irq_o);
        end
        // Offsets cancel by comparing against the first off span
        for (int i = 0; i < 5; i++) begin
            span(1'b0, 1'b0, n);
            wr(`OFS_REF_TIMER, pre[i]);
            wr(`OFS_OFF_TIME_LOW, lo[i]);
            wr(`OFS_OFF_TIME_HIGH, hi[i]);
            idle();
            span(1'b0, 1'b0, n);
            if (i == 0) begin
                b = n;
            end
            m = 64 * (pre[i] == 8'h00 ? 256 : int'(pre[i]));
            m = m * int'({hi[i][5:0], lo[i]});
            chk_span(m - 64, n - b);
        end
        // A smaller preset cuts the long on-time short, keeping the run brief
        wr(`OFS_REF_TIMER, 8'h01);
        wr(`OFS_OFF_TIME_HIGH, 8'h00);
        wr(`OFS_ON_TIME_A_LOW, 8'h04);
        wr(`OFS_ON_TIME_B_LOW, 8'h04);
        idle();
        meas(1'b0, 1'b1, b);
        wr(`OFS_POLL_CONTROL, {6'h00, `SEL_FAST_FALL});
        idle();
        meas(1'b0, 1'b1, n);
        chk_span(b - 192, n);
        wk.detect <= 1'b1;
        meas(1'b0, 1'b1, n);
        chk_span(b, n);
        wk.detect <= 1'b0;
        wr(`OFS_POLL_CONTROL, {6'h00, `SEL_MIXED});
        idle();
        meas(1'b0, 1'b1, n);
        span(1'b0, 1'b1, m);
        chk_span(192, n > m ? n - m : m - n);
        wr(`OFS_POLL_CONTROL, 8'h00);
        wr(`OFS_ON_TIME_A_LOW, 8'h08);
        wr(`OFS_ON_TIME_B_LOW, 8'h08);
        idle();
        meas(1'b1, 1'b1, b);
        wr(`OFS_ACTIVE_PERIODS, 8'he3);
        idle();
        meas(1'b1, 1'b1, n);
        chk_span(b + 128, n);
        meas(1'b0, 1'b1, m);
        wr(`OFS_POLL_CONTROL, 8'h08);
        idle();
        meas(1'b1, 1'b1, n);
        chk_span(m, n);
        wr(`OFS_POLL_CONTROL, 8'h04);
        idle();
        meas(1'b0, 1'b1, n);
        chk_span(m - 320, n);
        idle();
        idle();
        end_sim();
    end
endmodule
